/* File: include/twp_defs.svh */
// Constants of the three-wire register write port
`ifndef TWP_DEFS_SVH
`define TWP_DEFS_SVH

// =============================================================
// Addresses
`define TWP_ADDR_SYS    8'h14
`define TWP_ADDR_MODE_A 8'h15
`define TWP_ADDR_MODE_B 8'h16
`define TWP_ADDR_MODE   8'h0a
`define TWP_SYNC_FIRST  8'h0a
`define TWP_SYNC_LAST   8'h0e
`define TWP_CTRL_LAST   8'h0e

// =============================================================
// Array sizes and indices
`define TWP_CTRL_N      15
`define TWP_SYNC_N      5
`define TWP_SYNC_LO     10
`define TWP_SYS_N       17
`define TWP_MODE_N      8
`define TWP_MODE_IDX    10
`define TWP_SEL_BIT     0

// =============================================================
// Frame field ends and word counts
`define TWP_ADDR_END    5'h07
`define TWP_FIELD24_END 5'h17
`define TWP_WORD_END    5'h1f
`define TWP_IDX_MAX     5'h1f
`define TWP_SYS_WORDS   5'h11
`define TWP_MODE_WORDS  5'h08
`define TWP_CNT_ZERO    24'h000000
`define TWP_CNT_ONE     24'h000001
`define TWP_SYS_CNT     24'h000011
`define TWP_MODE_CNT    24'h000008

`endif

/* File: include/twp_pkg.sv */
// Types and shared decode of the three-wire register write port
package twp_pkg;
`include "twp_defs.svh"

   // Serial frame states, Gray along idle-addr-count-data-done
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_addr = 3'h1,
      st_cnt  = 3'h3,
      st_data = 3'h2,
      st_done = 3'h6,
      st_cdat = 3'h5
   } twp_state_t;

   function automatic logic twp_is_bank(input logic [7:0] addr);
      twp_is_bank = (addr == `TWP_ADDR_SYS) || (addr == `TWP_ADDR_MODE_A) ||
                    (addr == `TWP_ADDR_MODE_B);
   endfunction

   function automatic logic twp_is_sync(input logic [7:0] addr);
      twp_is_sync = (addr >= `TWP_SYNC_FIRST) && (addr <= `TWP_SYNC_LAST);
   endfunction

endpackage

/* File: src/twp_shift.sv */
// Serial frame decoder running on the shift clock
`include "twp_defs.svh"
module twp_shift
   import twp_pkg::*;
(
   // Link clock and its synchronised reset
   input  wire logic        shift_clk,
   input  wire logic        rst_sck_n,
   // Serial pins
   input  wire logic        load_strobe,
   input  wire logic        serial_data_line,
   // Completed word, stable until the next toggle
   output logic [31:0]      word_reg,
   output logic [7:0]       waddr_reg,
   output logic [4:0]       widx_reg,
   output logic             wlast_reg,
   output logic             wtgl_reg
);

   twp_state_t  state_reg;
   logic [4:0]  bit_reg;
   logic [31:0] sh_reg;
   logic [31:0] sh_next;
   logic [23:0] left_reg;
   logic [7:0]  cur_addr_reg;
   logic [4:0]  idx_reg;
   logic        emit;

   assign sh_next = {sh_reg[30:0], serial_data_line};
   assign emit = (state_reg == st_cdat && !load_strobe && bit_reg == `TWP_FIELD24_END) ||
                 (state_reg == st_data && bit_reg == `TWP_WORD_END);

   // =============================================================
   // Shift register
   always_ff @(posedge shift_clk or negedge rst_sck_n) begin
      if (!rst_sck_n) begin
         sh_reg <= 32'h0;
      end else begin
         sh_reg <= sh_next;
      end
   end

   // =============================================================
   // Frame sequencer
   always_ff @(posedge shift_clk or negedge rst_sck_n) begin
      if (!rst_sck_n) begin
         state_reg    <= st_idle;
         bit_reg      <= 5'h0;
         left_reg     <= `TWP_CNT_ZERO;
         cur_addr_reg <= 8'h0;
      end else begin
         case (state_reg)
            st_idle: begin
               if (!load_strobe) begin
                  bit_reg   <= 5'h1;
                  state_reg <= st_addr;
               end
            end
            st_addr: begin
               if (load_strobe) begin
                  state_reg <= st_idle;
               end else if (bit_reg == `TWP_ADDR_END) begin
                  bit_reg      <= 5'h0;
                  cur_addr_reg <= sh_next[7:0];
                  state_reg    <= twp_is_bank(sh_next[7:0]) ? st_cnt : st_cdat;
               end else begin
                  bit_reg <= bit_reg + 5'h1;
               end
            end
            st_cdat: begin
               // Strobe rising before all 24 bits drops the write
               if (load_strobe) begin
                  state_reg <= st_idle;
               end else if (bit_reg == `TWP_FIELD24_END) begin
                  state_reg <= st_done;
               end else begin
                  bit_reg <= bit_reg + 5'h1;
               end
            end
            st_cnt: begin
               // Strobe is not looked at again until the last word is in
               if (bit_reg == `TWP_FIELD24_END) begin
                  bit_reg   <= 5'h0;
                  state_reg <= st_data;
                  if (sh_next[23:0] != `TWP_CNT_ZERO) begin
                     left_reg <= sh_next[23:0];
                  end else if (cur_addr_reg == `TWP_ADDR_SYS) begin
                     left_reg <= `TWP_SYS_CNT;
                  end else begin
                     left_reg <= `TWP_MODE_CNT;
                  end
               end else begin
                  bit_reg <= bit_reg + 5'h1;
               end
            end
            st_data: begin
               if (bit_reg == `TWP_WORD_END) begin
                  bit_reg  <= 5'h0;
                  left_reg <= left_reg - `TWP_CNT_ONE;
                  if (left_reg == `TWP_CNT_ONE) begin
                     state_reg <= st_done;
                  end
               end else begin
                  bit_reg <= bit_reg + 5'h1;
               end
            end
            st_done: begin
               // Extra bits are ignored; only a high strobe re-arms the port
               if (load_strobe) begin
                  state_reg <= st_idle;
               end
            end
            default: begin
               state_reg <= st_idle;
            end
         endcase
      end
   end

   // =============================================================
   // Word hand-off
   always_ff @(posedge shift_clk or negedge rst_sck_n) begin
      if (!rst_sck_n) begin
         word_reg  <= 32'h0;
         waddr_reg <= 8'h0;
         widx_reg  <= 5'h0;
         wlast_reg <= 1'b0;
         wtgl_reg  <= 1'b0;
         idx_reg   <= 5'h0;
      end else begin
         if (state_reg == st_cnt) begin
            idx_reg <= 5'h0;
         end
         if (emit) begin
            word_reg  <= sh_next;
            waddr_reg <= cur_addr_reg;
            widx_reg  <= (state_reg == st_data) ? idx_reg : 5'h0;
            wlast_reg <= (state_reg == st_cdat) || (left_reg == `TWP_CNT_ONE);
            wtgl_reg  <= ~wtgl_reg;
            if (state_reg == st_data && idx_reg != `TWP_IDX_MAX) begin
               idx_reg <= idx_reg + 5'h1;
            end
         end
      end
   end

   // =============================================================
   // Checks
   a_strobe_ignored: assert property (@(posedge shift_clk) disable iff (!rst_sck_n)
      (state_reg == st_data && load_strobe && bit_reg != `TWP_WORD_END) |=>
         (state_reg == st_data))
      else $error("strobe aborted a bank transfer");

   a_count_zero_sys: assert property (@(posedge shift_clk) disable iff (!rst_sck_n)
      (state_reg == st_cnt && bit_reg == `TWP_FIELD24_END &&
       sh_next[23:0] == `TWP_CNT_ZERO && cur_addr_reg == `TWP_ADDR_SYS) |=>
         (left_reg == `TWP_SYS_CNT) && (state_reg == st_data))
      else $error("zero count did not expect 17 words");

   a_bank_route: assert property (@(posedge shift_clk) disable iff (!rst_sck_n)
      (state_reg == st_addr && !load_strobe && bit_reg == `TWP_ADDR_END &&
       twp_is_bank(sh_next[7:0])) |=> (state_reg == st_cnt))
      else $error("bank address not followed by count");

endmodule

/* File: src/twp_port.sv */
// Three-wire write-only register port with frame-synchronous updates
//
// Contract
// - Control write is 8 address bits then 24 data bits, one address per strobe.
// - Each data bit is sampled on the rising shift clock edge.
// - Shifted contents take effect at the strobe rising edge, not during shifting.
// - System bank write is address 0x14, 24-bit count, then 32-bit words.
// - A zero count means all 17 system words are expected.
// - Nonzero count N stores exactly N words into registers 0 to N-1, for N up to the bank's size.
// - After a bank address, strobe changes are ignored until the last expected data bit arrives.
// - Mode banks sit at 0x15 and 0x16, eight words each, same burst.
// - One select bit in control register 0x0A picks the active mode bank.
// - Immediate control registers update right at the strobe rising edge.
// - Frame-synchronous writes are buffered and moved at vertical sync falling edge.
// - Addresses 0x0A to 0x0E are frame-synchronous; the rest are immediate. Here only 0x00 to 0x09 are; control writes above 0x0E are dropped.
// - Bank writes apply at transfer end without waiting for vertical sync.
// - Control space runs 0x00 to 0xD6, 24 bits each, sparsely implemented.

`include "twp_defs.svh"
module twp_port
   import twp_pkg::*;
(
   // System clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     arst_n,
   // Serial port pins
   input  wire logic                     shift_clk,
   input  wire logic                     load_strobe,
   input  wire logic                     serial_data_line,
   // Frame timing
   input  wire logic                     vertical_sync,
   // Register contents seen by the timing core
   output logic [`TWP_CTRL_N-1:0][23:0]  ctrl_active_reg,
   output logic [`TWP_SYS_N-1:0][31:0]   sys_bank_reg,
   output logic [`TWP_MODE_N-1:0][31:0]  mode_active_reg,
   output logic                          mode_sel_reg,
   output logic [`TWP_SYNC_N-1:0]        sync_pend_reg
);

   // =============================================================
   // Reset synchronisers
   logic rst_s1_reg;
   logic rst_sys_n;
   logic rst_k1_reg;
   logic rst_sck_n;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_reg <= 1'b0;
         rst_sys_n  <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_sys_n  <= rst_s1_reg;
      end
   end

   // The link clock may stop between frames; its reset releases on its own edges
   always_ff @(posedge shift_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_k1_reg <= 1'b0;
         rst_sck_n  <= 1'b0;
      end else begin
         rst_k1_reg <= 1'b1;
         rst_sck_n  <= rst_k1_reg;
      end
   end

   // =============================================================
   // Link-side frame decoder
   logic [31:0] k_word;
   logic [7:0]  k_addr;
   logic [4:0]  k_idx;
   logic        k_last;
   logic        k_tgl;

   twp_shift u_shift (
      .shift_clk        (shift_clk),
      .rst_sck_n        (rst_sck_n),
      .load_strobe      (load_strobe),
      .serial_data_line (serial_data_line),
      .word_reg         (k_word),
      .waddr_reg        (k_addr),
      .widx_reg         (k_idx),
      .wlast_reg        (k_last),
      .wtgl_reg         (k_tgl)
   );

   // =============================================================
   // Crossings into the system clock
   logic tgl_s1_reg;
   logic tgl_s2_reg;
   logic tgl_s3_reg;
   logic sl_s1_reg;
   logic sl_s2_reg;
   logic vd_s1_reg;
   logic vd_s2_reg;
   logic vd_s3_reg;
   logic new_word;
   logic vd_fall;

   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
         sl_s1_reg  <= 1'b1;
         sl_s2_reg  <= 1'b1;
         vd_s1_reg  <= 1'b1;
         vd_s2_reg  <= 1'b1;
         vd_s3_reg  <= 1'b1;
      end else begin
         tgl_s1_reg <= k_tgl;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
         sl_s1_reg  <= load_strobe;
         sl_s2_reg  <= sl_s1_reg;
         vd_s1_reg  <= vertical_sync;
         vd_s2_reg  <= vd_s1_reg;
         vd_s3_reg  <= vd_s2_reg;
      end
   end

   // Word fields stay still for 32 shift clocks after a toggle, far longer
   // than the three system cycles the toggle needs to arrive.
   assign new_word = tgl_s2_reg ^ tgl_s3_reg;
   assign vd_fall  = vd_s3_reg & ~vd_s2_reg;

   // =============================================================
   // Received words: bank shadow and pending control write
   logic [`TWP_SYS_N-1:0][31:0] shadow_reg;
   logic                        bank_rdy_reg;
   logic [7:0]                  bank_addr_reg;
   logic [4:0]                  bank_n_reg;
   logic                        ctrl_rdy_reg;
   logic [7:0]                  ctrl_addr_reg;
   logic [23:0]                 ctrl_data_reg;
   logic                        commit_ctrl;
   logic                        commit_bank;

   // Strobe seen high after a complete frame marks the end of the write;
   // a strobe left high through the last bits of a bank transfer commits on arrival.
   assign commit_ctrl = ctrl_rdy_reg & sl_s2_reg;
   assign commit_bank = bank_rdy_reg & sl_s2_reg;

   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         shadow_reg    <= '0;
         bank_rdy_reg  <= 1'b0;
         bank_addr_reg <= 8'h0;
         bank_n_reg    <= 5'h0;
         ctrl_rdy_reg  <= 1'b0;
         ctrl_addr_reg <= 8'h0;
         ctrl_data_reg <= 24'h0;
      end else begin
         if (commit_ctrl) begin
            ctrl_rdy_reg <= 1'b0;
         end
         if (commit_bank) begin
            bank_rdy_reg <= 1'b0;
         end
         // A new word landing in the commit cycle wins over the clear
         if (new_word) begin
            if (twp_is_bank(k_addr)) begin
               if (k_idx < `TWP_SYS_WORDS) begin
                  shadow_reg[k_idx] <= k_word;
               end
               if (k_last) begin
                  bank_rdy_reg  <= 1'b1;
                  bank_addr_reg <= k_addr;
                  bank_n_reg    <= (k_idx == `TWP_IDX_MAX) ? k_idx : k_idx + 5'h1;
               end
            end else begin
               ctrl_rdy_reg  <= 1'b1;
               ctrl_addr_reg <= k_addr;
               ctrl_data_reg <= k_word[23:0];
            end
         end
      end
   end

   // =============================================================
   // Control registers: immediate and frame-synchronous
   logic [`TWP_SYNC_N-1:0][23:0] sync_buf_reg;
   logic [2:0]                   sync_idx;
   logic                         ctrl_impl;

   assign sync_idx  = 3'(ctrl_addr_reg - `TWP_SYNC_FIRST);
   assign ctrl_impl = ctrl_addr_reg <= `TWP_CTRL_LAST;

   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         ctrl_active_reg <= '0;
         sync_buf_reg    <= '0;
         sync_pend_reg   <= '0;
      end else begin
         if (vd_fall) begin
            for (int k = 0; k < `TWP_SYNC_N; k++) begin
               if (sync_pend_reg[k]) begin
                  ctrl_active_reg[`TWP_SYNC_LO + k] <= sync_buf_reg[k];
                  sync_pend_reg[k]                  <= 1'b0;
               end
            end
         end
         // A write committed together with the sync edge stays pending
         if (commit_ctrl && ctrl_impl) begin
            if (twp_is_sync(ctrl_addr_reg)) begin
               sync_buf_reg[sync_idx]  <= ctrl_data_reg;
               sync_pend_reg[sync_idx] <= 1'b1;
            end else begin
               ctrl_active_reg[ctrl_addr_reg[3:0]] <= ctrl_data_reg;
            end
         end
      end
   end

   // =============================================================
   // Banks
   logic [`TWP_MODE_N-1:0][31:0] mode_a_reg;
   logic [`TWP_MODE_N-1:0][31:0] mode_b_reg;

   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         sys_bank_reg <= '0;
         mode_a_reg   <= '0;
         mode_b_reg   <= '0;
      end else if (commit_bank) begin
         // Counts beyond a bank's size still clock through; words past the bank's last register store nothing
         for (int i = 0; i < `TWP_SYS_N; i++) begin
            if (5'(i) < bank_n_reg) begin
               if (bank_addr_reg == `TWP_ADDR_SYS) begin
                  sys_bank_reg[i] <= shadow_reg[i];
               end else if (i < `TWP_MODE_N && bank_addr_reg == `TWP_ADDR_MODE_A) begin
                  mode_a_reg[i] <= shadow_reg[i];
               end else if (i < `TWP_MODE_N && bank_addr_reg == `TWP_ADDR_MODE_B) begin
                  mode_b_reg[i] <= shadow_reg[i];
               end
            end
         end
      end
   end

   // =============================================================
   // Active mode bank
   // Switching is safe only once the chosen bank holds its data; the host
   // is relied on to load it first, nothing here guards the order.
   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         mode_sel_reg    <= 1'b0;
         mode_active_reg <= '0;
      end else begin
         mode_sel_reg    <= ctrl_active_reg[`TWP_MODE_IDX][`TWP_SEL_BIT];
         mode_active_reg <= ctrl_active_reg[`TWP_MODE_IDX][`TWP_SEL_BIT] ?
                            mode_b_reg : mode_a_reg;
      end
   end

   // =============================================================
   // Checks
   a_sync_hold_vd: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      !vd_fall |=> $stable(ctrl_active_reg[`TWP_CTRL_N-1:`TWP_SYNC_LO]))
      else $error("frame-synchronous register changed without sync edge");

   a_sync_transfer: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      (vd_fall && sync_pend_reg[0]) |=>
         (ctrl_active_reg[`TWP_SYNC_LO] == $past(sync_buf_reg[0])) && !sync_pend_reg[0] ||
         $past(commit_ctrl) && $past(ctrl_addr_reg) == `TWP_SYNC_FIRST)
      else $error("buffered value not moved at sync edge");

   a_sync_buffered: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      (commit_ctrl && twp_is_sync(ctrl_addr_reg)) |=>
         sync_pend_reg[$past(sync_idx)] &&
         (sync_buf_reg[$past(sync_idx)] == $past(ctrl_data_reg)))
      else $error("frame-synchronous write not buffered");

   a_immed_apply: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      (commit_ctrl && ctrl_impl && !twp_is_sync(ctrl_addr_reg)) |=>
         (ctrl_active_reg[$past(ctrl_addr_reg[3:0])] == $past(ctrl_data_reg)))
      else $error("immediate register not updated");

   a_unmapped_drop: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      (commit_ctrl && !ctrl_impl && !vd_fall) |=>
         $stable(ctrl_active_reg) && $stable(sync_pend_reg))
      else $error("unimplemented address had an effect");

   a_apply_on_commit: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      !$stable(ctrl_active_reg) |-> $past(commit_ctrl) || $past(vd_fall))
      else $error("control register changed outside a strobe or sync edge");

   a_bank_commit: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      (commit_bank && bank_addr_reg == `TWP_ADDR_SYS && bank_n_reg != 5'h0) |=>
         (sys_bank_reg[0] == $past(shadow_reg[0])) && !bank_rdy_reg)
      else $error("system bank not applied at transfer end");

   a_mode_follow: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      ($stable(ctrl_active_reg[`TWP_MODE_IDX][`TWP_SEL_BIT]) && $stable(mode_a_reg) &&
       $stable(mode_b_reg)) |=>
         (mode_active_reg == (mode_sel_reg ? $past(mode_b_reg) : $past(mode_a_reg))))
      else $error("active mode bank does not follow select bit");

   // =============================================================
   // Checks: ready flags and holds
   a_ctrl_clear: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      (commit_ctrl && !new_word) |=> !ctrl_rdy_reg)
      else $error("control write left ready after commit");

   a_bank_clear: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      (commit_bank && !new_word) |=> !bank_rdy_reg)
      else $error("bank write left ready after commit");

   a_immed_only: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      !commit_ctrl |=>
         $stable(ctrl_active_reg[`TWP_SYNC_LO-1:0]))
      else $error("immediate register changed without a commit");

   a_pend_rise: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      !commit_ctrl |=>
         ((sync_pend_reg & ~$past(sync_pend_reg)) == '0))
      else $error("pending flag set without a commit");

   a_vd_clear: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      (vd_fall && !commit_ctrl) |=> (sync_pend_reg == '0))
      else $error("pending flag survived a sync edge");

   a_sys_hold: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      !commit_bank |=> $stable(sys_bank_reg))
      else $error("system bank changed without a commit");

   a_mode_hold: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      !commit_bank |=>
         $stable(mode_a_reg) && $stable(mode_b_reg))
      else $error("mode bank changed without a commit");

   a_bank_upper: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
      (commit_bank && bank_addr_reg == `TWP_ADDR_SYS && bank_n_reg < `TWP_SYS_WORDS) |=>
         $stable(sys_bank_reg[`TWP_SYS_N-1]))
      else $error("system word beyond the count was written");

endmodule

/* File: bench/twp_host_model.sv */
// Host side model that drives the three-wire write port
module twp_host_model (
   // Serial pins
   output logic shift_clk,
   output logic load_strobe,
   output logic serial_data_line
);
   timeunit 1ns;
   timeprecision 1ps;

   // =============================================================
   // Pin drivers
   localparam time half_per = 24ns;

   initial begin
      shift_clk        = 1'b0;
      load_strobe      = 1'b1;
      serial_data_line = 1'b0;
   end

   // Data and strobe change while the clock is low, so each bit is stable at its rising edge
   task automatic bit_out(input logic b, input logic strobe_lvl);
      load_strobe      = strobe_lvl;
      serial_data_line = b;
      #half_per shift_clk = 1'b1;
      #half_per shift_clk = 1'b0;
   endtask

   // Strobe high for whole clock periods; data keeps moving so a stale bit cannot look valid
   task automatic idle(input int n);
      repeat (n) bit_out(~serial_data_line, 1'b1);
   endtask

   // One frame: address, 24-bit field, then n words built from base and word index
   task automatic frame(input logic [7:0] addr, input logic [23:0] mid, input int n,
                        input logic [7:0] base, input bit tog);
      logic [31:0] w;
      for (int i = 0; i < 8; i++) bit_out(addr[7-i], 1'b0);
      for (int i = 0; i < 24; i++) bit_out(mid[23-i], 1'b0);
      for (int k = 0; k < n; k++) begin
         w = {base, 24'(k)};
         // Optional strobe glitch inside the first word, which the port must ignore
         for (int i = 0; i < 32; i++) bit_out(w[31-i], tog && k == 0 && i >= 4 && i < 12);
      end
      idle(2);
   endtask
endmodule

/* File: bench/tb.sv */
// Self-checking testbench of the three-wire register write port
`include "twp_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // =============================================================
   // Signals
   typedef struct {logic [7:0] addr; logic [23:0] data; logic [4:0] pend;} twp_row_t;
   logic                          clk_sys;
   logic                          arst_n;
   logic                          vertical_sync;
   logic                          shift_clk;
   logic                          load_strobe;
   logic                          serial_data_line;
   logic [`TWP_CTRL_N-1:0][23:0]  ctrl_active_reg;
   logic [`TWP_SYS_N-1:0][31:0]   sys_bank_reg;
   logic [`TWP_MODE_N-1:0][31:0]  mode_active_reg;
   logic                          mode_sel_reg;
   logic [`TWP_SYNC_N-1:0]        sync_pend_reg;
   logic [`TWP_CTRL_N-1:0][23:0]  exp_ctrl;
   logic [`TWP_SYS_N-1:0][31:0]   exp_sys;
   logic [`TWP_MODE_N-1:0][31:0]  exp_a;
   logic [`TWP_MODE_N-1:0][31:0]  exp_b;
   int                            errors;
   int                            comparisons;
   twp_row_t                      rows [6];

   twp_port twp_port_inst (.clk_sys(clk_sys), .arst_n(arst_n), .shift_clk(shift_clk),
      .load_strobe(load_strobe), .serial_data_line(serial_data_line),
      .vertical_sync(vertical_sync), .ctrl_active_reg(ctrl_active_reg),
      .sys_bank_reg(sys_bank_reg), .mode_active_reg(mode_active_reg),
      .mode_sel_reg(mode_sel_reg), .sync_pend_reg(sync_pend_reg));
   twp_host_model twp_host_model_inst (.shift_clk(shift_clk), .load_strobe(load_strobe),
      .serial_data_line(serial_data_line));

   initial clk_sys = 1'b0;
   always #12.5ns clk_sys = ~clk_sys;

   // =============================================================
   // Helpers
   task automatic check(input string name, input logic [543:0] seen, input logic [543:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Commit takes a few system cycles after the strobe rises and crosses domains
   task automatic settle();
      repeat (10) @(posedge clk_sys);
   endtask

   task automatic vsync_fall();
      @(posedge clk_sys);
      #2 vertical_sync = 1'b0;
      settle();
      @(posedge clk_sys);
      #2 vertical_sync = 1'b1;
      settle();
   endtask

   // =============================================================
   // Sequence
   initial begin
      #2ms;
      errors++;
      final_report();
   end

   initial begin
      errors = 0;
      comparisons = 0;
      arst_n = 1'b0;
      vertical_sync = 1'b1;
      exp_ctrl = '0;
      exp_sys = '0;
      exp_a = '0;
      exp_b = '0;
      rows = '{'{8'h00, 24'h123456, 5'h00}, '{8'h09, 24'habcdef, 5'h00},
               '{8'h0f, 24'h555555, 5'h00}, '{8'hd6, 24'h0f0f0f, 5'h00},
               '{8'h0c, 24'h777777, 5'h04}, '{8'h0e, 24'h0e0e0e, 5'h14}};
      repeat (12) @(posedge clk_sys);
      #2 arst_n = 1'b1;
      twp_host_model_inst.idle(4);
      settle();
      check("reset ctrl", 544'(ctrl_active_reg), 544'(exp_ctrl));
      check("reset sys", 544'(sys_bank_reg), 544'(exp_sys));
      check("reset sel", 544'(mode_sel_reg), 544'(1'b0));
      check("reset pend", 544'(sync_pend_reg), 544'(5'h00));
      foreach (rows[r]) begin
         twp_host_model_inst.frame(rows[r].addr, rows[r].data, 0, 8'h00, 1'b0);
         settle();
         if (rows[r].addr < 8'h0a)
            exp_ctrl[rows[r].addr[3:0]] = rows[r].data;
         check("ctrl", 544'(ctrl_active_reg), 544'(exp_ctrl));
         check("pend", 544'(sync_pend_reg), 544'(rows[r].pend));
      end
      for (int i = 0; i < 24; i++) twp_host_model_inst.bit_out(i >= 7, 1'b0);
      twp_host_model_inst.idle(2);
      settle();
      check("cut", 544'(ctrl_active_reg), 544'(exp_ctrl));
      vsync_fall();
      exp_ctrl[12] = 24'h777777;
      exp_ctrl[14] = 24'h0e0e0e;
      check("ctrl vsync", 544'(ctrl_active_reg), 544'(exp_ctrl));
      check("pend vsync", 544'(sync_pend_reg), 544'(5'h00));
      twp_host_model_inst.frame(8'h14, 24'h000000, 17, 8'h51, 1'b1);
      settle();
      for (int k = 0; k < 17; k++) exp_sys[k] = {8'h51, 24'(k)};
      check("sys full", 544'(sys_bank_reg), 544'(exp_sys));
      twp_host_model_inst.frame(8'h14, 24'h000002, 2, 8'h62, 1'b0);
      settle();
      for (int k = 0; k < 2; k++) exp_sys[k] = {8'h62, 24'(k)};
      check("sys part", 544'(sys_bank_reg), 544'(exp_sys));
      twp_host_model_inst.frame(8'h15, 24'h000000, 8, 8'h7a, 1'b0);
      twp_host_model_inst.frame(8'h16, 24'h000003, 3, 8'h8b, 1'b1);
      settle();
      for (int k = 0; k < 8; k++) exp_a[k] = {8'h7a, 24'(k)};
      for (int k = 0; k < 3; k++) exp_b[k] = {8'h8b, 24'(k)};
      check("mode a", 544'(mode_active_reg), 544'(exp_a));
      twp_host_model_inst.frame(8'h0a, 24'h000001, 0, 8'h00, 1'b0);
      settle();
      check("sel held", 544'(mode_sel_reg), 544'(1'b0));
      check("pend sel", 544'(sync_pend_reg), 544'(5'h01));
      vsync_fall();
      exp_ctrl[10] = 24'h000001;
      check("sel", 544'(mode_sel_reg), 544'(1'b1));
      check("mode b", 544'(mode_active_reg), 544'(exp_b));
      check("ctrl sel", 544'(ctrl_active_reg), 544'(exp_ctrl));
      final_report();
   end
endmodule
